// [rtl/wdtw_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  windowed watchdog. Assumes inclusion by the top module and the bench.
*/
`ifndef WDTW_REGS_SVH
`define WDTW_REGS_SVH

`define WDTW_RSTCTL_OFS 8'h00
`define WDTW_STAT_OFS   8'h04
`define WDTW_MASK_OFS   8'h08
`define WDTW_CNT_OFS    8'h0c
`define WDTW_CFG_OFS    8'h10

`define WDTW_SWEN_BIT 5
`define WDTW_TOF_BIT  4
`define WDTW_SLP_BIT  3
`define WDTW_IDL_BIT  2

`define WDTW_EV_TOUT  0
`define WDTW_EV_EARLY 1
`define WDTW_EV_WAKE  2
`define WDTW_EV_RST   3'h0

`define WDTW_OSC_HZ       32000
`define WDTW_PER_SHORT_US 1000
`define WDTW_PER_LONG_US  4000
`define WDTW_PRE_SHORT_DIV (`WDTW_OSC_HZ * `WDTW_PER_SHORT_US / 1000000)
`define WDTW_PRE_LONG_DIV  (`WDTW_OSC_HZ * `WDTW_PER_LONG_US / 1000000)
`define WDTW_PRE_SHORT_SH 5
`define WDTW_PRE_LONG_SH  7

`endif

// [rtl/wdtw_pkg.sv]
/*
  Types of the windowed watchdog: configuration word and power states.
  Assumes nothing of its surroundings.
*/
package wdtw_pkg;

  typedef struct packed {
    logic       fuse_watchdog_enable;
    logic       window_mode_disable;
    logic       spare;
    logic       prescale_select_bit;
    logic [3:0] postscale_select_field;
  } wdtw_cfg_t;

  typedef enum logic [1:0] {
    WDTW_RUN,
    WDTW_SLEEP,
    WDTW_IDLE
  } wdtw_state_t;

endpackage : wdtw_pkg

// [rtl/wdtw_top.sv]
/*
  Windowed watchdog timer with an AXI4-Lite register slave and a level
  interrupt. Assumes one 40 MHz clock, a synchronous active-high reset,
  a free oscillator input that is slow against the clock, and one-cycle
  instruction and event strobes from logic on the same clock.
*/
// Contract
// - count on low-power oscillator, enable turns it on
// - prescaler divides by 32 or 128
// - prescaler period 1 ms or 4 ms
// - postscaler 16 ratios from 1:1 to 1:32768
// - any device reset clears all counters
// - completed clock switch clears all counters
// - power-save entry clears all counters
// - power-save exit clears all counters
// - clear instruction clears all counters; here only in run state, ignored in sleep/idle
// - counts in sleep/idle, time-out wakes device
// - fuse enable forces watchdog always on
// - otherwise software enable bit runs watchdog
// - device reset clears software enable bit
// - early clear in window mode resets device
// - sticky time-out flag until software clears
`timescale 1ns/1ps
`include "wdtw_regs.svh"

module wdtw_top
  import wdtw_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        DEV_RST,
  input  wire logic        LOW_POWER_RC_OSCILLATOR,
  input  wire logic        WATCHDOG_CLEAR_INSTRUCTION,
  input  wire logic        POWER_SAVE_INSTRUCTION,
  input  wire logic        POWER_SAVE_IDLE,
  input  wire logic        WAKE_EVT,
  input  wire logic        CLKSW_DONE,
  input  wire wdtw_cfg_t   CFG_WORD,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             LOW_POWER_RC_OSCILLATOR_EN,
  output logic             WDT_RESET,
  output logic             WAKE_REQ,
  output logic             IRQ
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  wdtw_cfg_t   cfg_r;
  wdtw_state_t state_r;
  logic        osc_s1_r;
  logic        osc_s2_r;
  logic        osc_s3_r;
  logic [6:0]  pre_cnt_r;
  logic [14:0] post_cnt_r;
  logic        swen_r;
  logic        tof_r;
  logic        slp_r;
  logic        idl_r;
  logic [2:0]  stat_r;
  logic [2:0]  mask_r;
  logic        wdt_rst_r;
  logic        wake_r;
  logic        aw_ok_r;
  logic        w_ok_r;
  logic [7:0]  awaddr_r;
  logic [7:0]  wdata_r;
  logic        wlane_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  logic        wdt_en;
  logic        osc_tick;
  logic        running;
  logic        psave_go;
  logic        clear_run;
  logic        exit_ps;
  logic        any_dev_rst;
  logic        clr_cnt;
  logic [6:0]  pre_last;
  logic        pre_end;
  logic [14:0] post_last;
  logic        post_end;
  logic        tout;
  logic        early;
  logic [21:0] elapsed;
  logic [22:0] total;
  logic [22:0] win_start;
  logic        win_open;
  logic        wr_go;
  logic        rd_go;
  logic        wr_map;
  logic        w1c_tof;
  logic        w1c_slp;
  logic        w1c_idl;
  logic [2:0]  ev;
  logic [2:0]  stat_w1c;
  logic [31:0] rd_mux;
  logic        rd_map;

  // ---------------------------------------------------------------
  // Configuration word
  // ---------------------------------------------------------------
  // The word is fuse-like: caught while reset is held and frozen after
  // release, so software cannot defeat the fuse enable at run time.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cfg_r <= CFG_WORD;
    end
  end

  // ---------------------------------------------------------------
  // Oscillator input and enable
  // ---------------------------------------------------------------
  assign wdt_en  = cfg_r.fuse_watchdog_enable | swen_r;
  assign LOW_POWER_RC_OSCILLATOR_EN = wdt_en;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= LOW_POWER_RC_OSCILLATOR;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // One tick per rising oscillator edge, only while enabled.
  assign osc_tick = wdt_en & osc_s2_r & ~osc_s3_r;

  // ---------------------------------------------------------------
  // Clearing events
  // ---------------------------------------------------------------
  assign running     = (state_r == WDTW_RUN);
  assign psave_go    = POWER_SAVE_INSTRUCTION & running;
  assign clear_run   = WATCHDOG_CLEAR_INSTRUCTION & running;
  assign exit_ps     = ~running & (WAKE_EVT | tout);
  assign any_dev_rst = SRST | DEV_RST | wdt_rst_r;

  assign clr_cnt = any_dev_rst
                 | CLKSW_DONE
                 | psave_go
                 | exit_ps
                 | clear_run;

  // ---------------------------------------------------------------
  // Prescaler and postscaler
  // ---------------------------------------------------------------
  assign pre_last = cfg_r.prescale_select_bit ?
                    7'(`WDTW_PRE_LONG_DIV - 1) :
                    7'(`WDTW_PRE_SHORT_DIV - 1);
  assign pre_end  = (pre_cnt_r == pre_last);

  assign post_last = 15'((16'h0001 << cfg_r.postscale_select_field) - 16'h0001);
  assign post_end  = (post_cnt_r == post_last);

  assign tout = osc_tick & pre_end & post_end;

  always_ff @(posedge CLK) begin
    if (clr_cnt) begin
      pre_cnt_r <= 7'h00;
    end else if (osc_tick) begin
      pre_cnt_r <= pre_end ? 7'h00 : pre_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (clr_cnt) begin
      post_cnt_r <= 15'h0000;
    end else if (osc_tick && pre_end) begin
      post_cnt_r <= post_end ? 15'h0000 : post_cnt_r + 15'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Clear window
  // ---------------------------------------------------------------
  // Elapsed oscillator ticks in the period; the window is the last
  // quarter of the whole period, prescaler and postscaler together.
  assign elapsed = cfg_r.prescale_select_bit ?
                   {post_cnt_r, pre_cnt_r} :
                   {2'b00, post_cnt_r, pre_cnt_r[4:0]};
  assign total = 23'h000001 << (5'(cfg_r.postscale_select_field) +
                 (cfg_r.prescale_select_bit ? 5'(`WDTW_PRE_LONG_SH) :
                                              5'(`WDTW_PRE_SHORT_SH)));
  assign win_start = total - (total >> 2);
  assign win_open  = ({1'b0, elapsed} >= win_start);
  assign early = clear_run & wdt_en & ~cfg_r.window_mode_disable & ~win_open;

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (any_dev_rst) begin
      state_r <= WDTW_RUN;
    end else begin
      case (state_r)
        WDTW_RUN: begin
          if (psave_go) begin
            state_r <= POWER_SAVE_IDLE ? WDTW_IDLE : WDTW_SLEEP;
          end
        end
        WDTW_SLEEP, WDTW_IDLE: begin
          if (exit_ps) begin
            state_r <= WDTW_RUN;
          end
        end
        default: begin
          state_r <= WDTW_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Reset and wake outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wdt_rst_r <= 1'b0;
      wake_r    <= 1'b0;
    end else begin
      wdt_rst_r <= (tout & running) | early;
      wake_r    <= tout & ~running;
    end
  end

  assign WDT_RESET = wdt_rst_r;
  assign WAKE_REQ  = wake_r;

  // ---------------------------------------------------------------
  // Reset control register
  // ---------------------------------------------------------------
  assign wr_go   = aw_ok_r & w_ok_r & ~bvalid_r;
  assign wr_map  = (awaddr_r == `WDTW_RSTCTL_OFS) | (awaddr_r == `WDTW_STAT_OFS) |
                   (awaddr_r == `WDTW_MASK_OFS) | (awaddr_r == `WDTW_CNT_OFS) |
                   (awaddr_r == `WDTW_CFG_OFS);
  assign w1c_tof = wr_go & wlane_r & (awaddr_r == `WDTW_RSTCTL_OFS) &
                   wdata_r[`WDTW_TOF_BIT];
  assign w1c_slp = wr_go & wlane_r & (awaddr_r == `WDTW_RSTCTL_OFS) &
                   wdata_r[`WDTW_SLP_BIT];
  assign w1c_idl = wr_go & wlane_r & (awaddr_r == `WDTW_RSTCTL_OFS) &
                   wdata_r[`WDTW_IDL_BIT];

  always_ff @(posedge CLK) begin
    if (any_dev_rst) begin
      swen_r <= 1'b0;
    end else if (wr_go && wlane_r && awaddr_r == `WDTW_RSTCTL_OFS) begin
      swen_r <= wdata_r[`WDTW_SWEN_BIT];
    end
  end

  // The time-out flag survives the reset it causes; set wins over clear.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tof_r <= 1'b0;
    end else if (tout) begin
      tof_r <= 1'b1;
    end else if (w1c_tof) begin
      tof_r <= 1'b0;
    end
  end

  // Hardware only sets these; software must clear them after a wake.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      slp_r <= 1'b0;
      idl_r <= 1'b0;
    end else begin
      if (psave_go && !POWER_SAVE_IDLE) begin
        slp_r <= 1'b1;
      end else if (w1c_slp) begin
        slp_r <= 1'b0;
      end
      if (psave_go && POWER_SAVE_IDLE) begin
        idl_r <= 1'b1;
      end else if (w1c_idl) begin
        idl_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  assign ev[`WDTW_EV_TOUT]  = tout;
  assign ev[`WDTW_EV_EARLY] = early;
  assign ev[`WDTW_EV_WAKE]  = tout & ~running;
  assign stat_w1c = (wr_go && wlane_r && awaddr_r == `WDTW_STAT_OFS) ?
                    wdata_r[2:0] : 3'h0;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      stat_r <= `WDTW_EV_RST;
    end else begin
      stat_r <= ev | (stat_r & ~stat_w1c);
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_r <= `WDTW_EV_RST;
    end else if (wr_go && wlane_r && awaddr_r == `WDTW_MASK_OFS) begin
      mask_r <= wdata_r[2:0];
    end
  end

  assign IRQ = |(stat_r & mask_r);

  // ---------------------------------------------------------------
  // AXI4-Lite write channels
  // ---------------------------------------------------------------
  assign S_AXI_AWREADY = ~aw_ok_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_ok_r & ~bvalid_r;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_ok_r  <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_ok_r  <= 1'b1;
      awaddr_r <= {S_AXI_AWADDR[7:2], 2'b00};
    end else if (wr_go) begin
      aw_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      w_ok_r  <= 1'b0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_ok_r  <= 1'b1;
      wdata_r <= S_AXI_WDATA[7:0];
      wlane_r <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      bvalid_r <= 1'b0;
      bresp_r  <= 2'b00;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_map ? 2'b00 : 2'b10;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP  = bresp_r;

  // ---------------------------------------------------------------
  // AXI4-Lite read channels
  // ---------------------------------------------------------------
  assign S_AXI_ARREADY = ~rvalid_r;
  assign rd_go         = S_AXI_ARVALID & ~rvalid_r;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `WDTW_RSTCTL_OFS: begin
        rd_mux[`WDTW_SWEN_BIT] = swen_r;
        rd_mux[`WDTW_TOF_BIT]  = tof_r;
        rd_mux[`WDTW_SLP_BIT]  = slp_r;
        rd_mux[`WDTW_IDL_BIT]  = idl_r;
      end
      `WDTW_STAT_OFS: rd_mux[2:0] = stat_r;
      `WDTW_MASK_OFS: rd_mux[2:0] = mask_r;
      `WDTW_CNT_OFS: begin
        rd_mux[21:0]  = elapsed;
        rd_mux[25:24] = state_r;
      end
      `WDTW_CFG_OFS: rd_mux[7:0] = cfg_r;
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'b00;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_map ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA  = rdata_r;
  assign S_AXI_RRESP  = rresp_r;

endmodule : wdtw_top

// [bench/wdtw_top_assertions.sv]
/*
  Port checker of the windowed watchdog, bound into wdtw_top.
  Assumes CFG_WORD changes only while SRST is high.
*/
`timescale 1ns/1ps

module wdtw_chk
  import wdtw_pkg::*;
(
  input wire logic      CLK,
  input wire logic      SRST,
  input wire logic      DEV_RST,
  input wire wdtw_cfg_t CFG_WORD,
  input wire logic      S_AXI_AWVALID,
  input wire logic      S_AXI_AWREADY,
  input wire logic      S_AXI_WVALID,
  input wire logic      S_AXI_WREADY,
  input wire logic      S_AXI_BVALID,
  input wire logic      S_AXI_BREADY,
  input wire logic      S_AXI_ARVALID,
  input wire logic      S_AXI_ARREADY,
  input wire logic      S_AXI_RVALID,
  input wire logic      S_AXI_RREADY,
  input wire logic      LOW_POWER_RC_OSCILLATOR_EN,
  input wire logic      WDT_RESET,
  input wire logic      WAKE_REQ,
  input wire logic      IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_rd_done;
    S_AXI_RVALID && S_AXI_RREADY;
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID)
    else $error("read response late");
  a_bresp_drops: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_rresp_drops: assert property (s_rd_done |=> !S_AXI_RVALID)
    else $error("read response repeated");
  a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write address accepted during response");

  // ----------------------------------------------------------------
  // Watchdog outputs
  // ----------------------------------------------------------------
  a_reset_pulse_one: assert property (WDT_RESET |=> !WDT_RESET)
    else $error("reset request longer than one cycle");
  a_wake_not_reset: assert property (!(WDT_RESET && WAKE_REQ))
    else $error("wake and reset together");
  a_fuse_keeps_on: assert property ((CFG_WORD.fuse_watchdog_enable)[*3]
                                    |-> LOW_POWER_RC_OSCILLATOR_EN)
    else $error("oscillator off under fuse enable");
  a_off_no_timeout: assert property (!LOW_POWER_RC_OSCILLATOR_EN
                                     && !$past(LOW_POWER_RC_OSCILLATOR_EN)
                                     |-> !WDT_RESET && !WAKE_REQ)
    else $error("time-out while disabled");
  a_devrst_drops_en: assert property (DEV_RST && !CFG_WORD.fuse_watchdog_enable
                                      |-> ##[1:2] !LOW_POWER_RC_OSCILLATOR_EN)
    else $error("software enable survived device reset");
  // Status bits only move on an event pulse or a completed register write.
  a_irq_cause: assert property ($rose(IRQ) |-> WDT_RESET || WAKE_REQ || S_AXI_BVALID
                                || $past(WDT_RESET || WAKE_REQ || S_AXI_BVALID))
    else $error("interrupt without cause");
endmodule : wdtw_chk

bind wdtw_top wdtw_chk chk_u (
  .CLK(CLK), .SRST(SRST), .DEV_RST(DEV_RST), .CFG_WORD(CFG_WORD),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .LOW_POWER_RC_OSCILLATOR_EN(LOW_POWER_RC_OSCILLATOR_EN),
  .WDT_RESET(WDT_RESET), .WAKE_REQ(WAKE_REQ), .IRQ(IRQ)
);

// [bench/wdtw_top_tb.sv]
/*
  Self-checking bench of the windowed watchdog: registers, ratios, clears,
  power-save wake and the clear window. Assumes wdtw_top and its checker.
*/
`timescale 1ns/1ps
`include "wdtw_regs.svh"

module wdtw_top_tb
  import wdtw_pkg::*;
;
  localparam int LIMIT = 20000;
  logic        clk, srst, dev_rst, osc, clr, psv, psv_idle, wake, clksw;
  wdtw_cfg_t   cfg;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, osc_en, wdt_rst, wake_req, irq;
  int          bad_count, compares, cyc, rst_cnt, wake_cnt, seed, b, n;
  int          ev[4] = '{0, 2, 4, 1};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  wdtw_top dut_u (
    .CLK(clk), .SRST(srst), .DEV_RST(dev_rst), .LOW_POWER_RC_OSCILLATOR(osc),
    .WATCHDOG_CLEAR_INSTRUCTION(clr), .POWER_SAVE_INSTRUCTION(psv),
    .POWER_SAVE_IDLE(psv_idle),
    .WAKE_EVT(wake), .CLKSW_DONE(clksw), .CFG_WORD(cfg),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LOW_POWER_RC_OSCILLATOR_EN(osc_en),
    .WDT_RESET(wdt_rst), .WAKE_REQ(wake_req), .IRQ(irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic wdtw_cfg_t mk(logic f, logic w, logic p, logic [3:0] s);
    return {f, w, 1'b0, p, s};
  endfunction : mk

  function automatic int period(wdtw_cfg_t c);
    return (c.prescale_select_bit ? 128 : 32) << c.postscale_select_field;
  endfunction : period

  function automatic logic [1:0] exp_resp(logic [7:0] a);
    return (a[7:2] > 6'h04) ? 2'b10 : 2'b00;
  endfunction : exp_resp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check(32'(bresp), 32'(exp_resp(a)));
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_d = rdata;
    check(32'(rresp), 32'(exp_resp(a)));
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Each oscillator period spans 8 clocks, enough for the synchroniser lag.
  task automatic ticks(input int k);
    repeat (k) begin
      osc <= 1'b1;
      repeat (4) @(posedge clk);
      osc <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : ticks

  task automatic pulse(input int e);
    case (e)
      0: clr <= 1'b1;
      1: psv <= 1'b1;
      2: clksw <= 1'b1;
      3: wake <= 1'b1;
      default: dev_rst <= 1'b1;
    endcase
    @(posedge clk);
    {clr, psv, clksw, wake, dev_rst} <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic do_reset(input wdtw_cfg_t c);
    srst <= 1'b1;
    cfg  <= c;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdt_rst === 1'b1) rst_cnt <= rst_cnt + 1;
    if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h7de5;
    {srst, cfg} <= {1'b1, 8'h00};
    {dev_rst, osc, clr, psv, psv_idle, wake, clksw} <= '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} <= '0;
    @(posedge clk);
    do_reset(mk(1'b0, 1'b1, 1'b0, 4'h0));
    check(32'(osc_en), 32'h0);
    rd(`WDTW_RSTCTL_OFS);
    check(rd_d, 32'h0);
    rd(`WDTW_CFG_OFS);
    check(rd_d, 32'(cfg));
    repeat (4) rd(8'($random(seed)) & 8'h3c);
    ticks(40);
    rd(`WDTW_CNT_OFS);
    check(rd_d, 32'h0);
    check(32'(rst_cnt), 32'h0);
    done("disabled");
    wr(`WDTW_RSTCTL_OFS, {$random(seed)} & 32'hffffff00 | 32'h20);
    check(32'(osc_en), 32'h1);
    ticks(31);
    rd(`WDTW_CNT_OFS);
    check(rd_d, 32'd31);
    ticks(1);
    check(32'(rst_cnt), 32'h1);
    check(32'(osc_en), 32'h0);
    wr(`WDTW_RSTCTL_OFS, 32'h20);
    pulse(4);
    rd(`WDTW_RSTCTL_OFS);
    check(rd_d, 32'h10);
    wr(`WDTW_MASK_OFS, 32'h1);
    check(32'(irq), 32'h1);
    wr(`WDTW_MASK_OFS, 32'h6);
    check(32'(irq), 32'h0);
    wr(`WDTW_STAT_OFS, 32'h7);
    wr(`WDTW_RSTCTL_OFS, 32'h10);
    rd(`WDTW_RSTCTL_OFS);
    check(rd_d, 32'h0);
    done("enable");
    for (int i = 0; i < 4; i++) begin
      do_reset(mk(1'b1, 1'b1, i[0], 4'(i / 2 * (2 - i % 2))));
      n = period(cfg);
      b = rst_cnt;
      check(32'(osc_en), 32'h1);
      ticks(n - 1);
      check(32'(rst_cnt), 32'(b));
      ticks(1);
      check(32'(rst_cnt), 32'(b + 1));
    end
    done("ratios");
    do_reset(mk(1'b1, 1'b1, 1'b0, 4'h0));
    b = rst_cnt;
    foreach (ev[k]) begin
      ticks(20);
      pulse(ev[k]);
      rd(`WDTW_CNT_OFS);
      check(rd_d, (ev[k] == 1) ? 32'h0100_0000 : 32'h0);
    end
    ticks(10);
    pulse(3);
    rd(`WDTW_CNT_OFS);
    check(rd_d, 32'h0);
    check(32'(rst_cnt), 32'(b));
    done("clears");
    wr(`WDTW_RSTCTL_OFS, 32'h1c);
    for (int i = 0; i < 2; i++) begin
      psv_idle <= i[0];
      pulse(1);
      b = rst_cnt;
      n = wake_cnt;
      ticks(16);
      pulse(0);
      ticks(16);
      check(32'(wake_cnt), 32'(n + 1));
      check(32'(rst_cnt), 32'(b));
      rd(`WDTW_RSTCTL_OFS);
      check(rd_d & 32'h1c, i[0] ? 32'h14 : 32'h18);
      wr(`WDTW_RSTCTL_OFS, 32'h1c);
    end
    rd(`WDTW_CNT_OFS);
    check(32'(rd_d[25:24]), 32'h0);
    done("power-save");
    do_reset(mk(1'b1, 1'b0, 1'b0, 4'h0));
    b = rst_cnt;
    ticks(23);
    pulse(0);
    check(32'(rst_cnt), 32'(b + 1));
    rd(`WDTW_STAT_OFS);
    check(rd_d & 32'h2, 32'h2);
    ticks(24);
    pulse(0);
    ticks(24 + {$random(seed)} % 8);
    pulse(0);
    check(32'(rst_cnt), 32'(b + 1));
    done("window");
    give_verdict();
  end
endmodule : wdtw_top_tb
